// ===== dv/ccp_pin_model.sv
// External signal source on the capture/compare pin
`default_nettype none
module ccp_pin_model (
   input  wire logic clk,
   input  wire logic pin_out,
   input  wire logic pin_oe_n,
   output logic      pin_in
);
   timeunit 1ns;
   timeprecision 100ps;
   logic lvl = 1'b0;

   // Device drive wins while its enable is low
   assign pin_in = pin_oe_n ? lvl : pin_out;

   // One level change, then a quiet spell longer than the synchroniser
   task automatic toggle;
      @(posedge clk);
      lvl <= ~lvl;
      repeat (8) @(posedge clk);
   endtask : toggle
endmodule : ccp_pin_model
`default_nettype wire

// ===== dv/gp_timer_16bit_asserts.sv
// Port-level checks for the 16-bit timer half
`default_nettype none
module gp_timer_16bit_asserts (
   input wire logic        CLOCK,
   input wire logic        RST,
   input wire logic        WB_CYC_I,
   input wire logic        WB_STB_I,
   input wire logic        WB_WE_I,
   input wire logic [7:0]  WB_ADR_I,
   input wire logic [31:0] WB_DAT_O,
   input wire logic        WB_ACK_O,
   input wire logic        CAPTURE_COMPARE_PIN_OUT,
   input wire logic        CAPTURE_COMPARE_PIN_OE_N,
   input wire logic        TRIGGER_OUT,
   input wire logic        IRQ
);
   // Acked clear or mask write, the only ways an interrupt may drop
   logic wr_clr;
   assign wr_clr = WB_ACK_O & WB_WE_I & (WB_ADR_I == 8'h24 | WB_ADR_I == 8'h18);

   default clocking @(posedge CLOCK); endclocking
   default disable iff (RST);

   // Fresh request, not the tail of one just answered
   sequence req_s;
      WB_CYC_I && WB_STB_I && !WB_ACK_O && !$past(WB_ACK_O);
   endsequence

   ack_timing_a: assert property (req_s |=> WB_ACK_O)
      else $error("no ack one cycle after request");
   ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("ack held longer than one cycle");
   ack_idle_a: assert property (!(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O)
      else $error("ack without request");
   clear_reads_zero_a: assert property ((WB_ACK_O && !WB_WE_I && WB_ADR_I == 8'h24) |-> WB_DAT_O == 32'h0)
      else $error("clear register read not zero");
   trig_pulse_a: assert property (TRIGGER_OUT |=> !TRIGGER_OUT)
      else $error("trigger longer than one cycle");
   pwm_no_trig_a: assert property (!CAPTURE_COMPARE_PIN_OE_N |-> !TRIGGER_OUT)
      else $error("trigger while in pwm");
   pin_idle_a: assert property (CAPTURE_COMPARE_PIN_OE_N |-> !CAPTURE_COMPARE_PIN_OUT)
      else $error("pin level outside pwm");
   irq_sticky_a: assert property ($fell(IRQ) |-> ($past(wr_clr) || $past(wr_clr, 2) || $past(wr_clr, 3)))
      else $error("interrupt dropped without clear");
endmodule : gp_timer_16bit_asserts

bind gp_timer_16bit gp_timer_16bit_asserts u_chk (
   .CLOCK(CLOCK), .RST(RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
   .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
   .CAPTURE_COMPARE_PIN_OUT(CAPTURE_COMPARE_PIN_OUT),
   .CAPTURE_COMPARE_PIN_OE_N(CAPTURE_COMPARE_PIN_OE_N),
   .TRIGGER_OUT(TRIGGER_OUT), .IRQ(IRQ)
);
`default_nettype wire

// ===== dv/tb_gp_timer_16bit.sv
// Self-checking bench for the 16-bit timer half
`default_nettype none
module tb_gp_timer_16bit;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk, rst, cyc, stb, we, ack, pin_in, pin_out, oe_n, trig, irq;
   logic [7:0]  adr;
   logic [31:0] dat, dat_o;
   int          fails, num_checks;
   int          cnt = 0;

   gp_timer_16bit u_dut (
      .CLOCK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
      .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
      .CAPTURE_COMPARE_PIN_IN(pin_in), .CAPTURE_COMPARE_PIN_OUT(pin_out),
      .CAPTURE_COMPARE_PIN_OE_N(oe_n), .TRIGGER_OUT(trig), .IRQ(irq)
   );
   ccp_pin_model u_pin (.clk(clk), .pin_out(pin_out), .pin_oe_n(oe_n), .pin_in(pin_in));

   // Clock, plus a cycle count used to stamp pin edges
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) cnt <= cnt + 1;

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         fails++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk

   // One classic cycle; request held until ack is sampled
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      dat <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) fails++;
      q = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      bus(1'b0, a, 32'h0, q);
   endtask : rd

   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      rd(a, q);
      chk(q, e);
   endtask : rc

   task automatic t_reset;
      rc(8'h08, 32'hffff);
      rc(8'h10, 32'h0);
      rc(8'h14, 32'hffff);
      rc(8'h00, 32'h0);
      rc(8'h1c, 32'h0);
      rc(8'h40, 32'h0);
      rc(8'h24, 32'h0);
   endtask : t_reset

   task automatic t_oneshot;
      int n;
      n = 0;
      wr(8'h18, 32'h7);
      wr(8'h08, 32'h5);
      wr(8'h04, 32'h1);
      wr(8'h00, 32'h11);
      while (trig !== 1'b1 && n < 100) begin
         @(posedge clk);
         n++;
      end
      chk(32'(trig), 32'h1);
      repeat (3) @(posedge clk);
      chk(32'(irq), 32'h1);
      rc(8'h1c, 32'h1);
      rc(8'h20, 32'h1);
      rc(8'h00, 32'h10);
      rc(8'h14, 32'h5);
      wr(8'h24, 32'h0);
      rc(8'h1c, 32'h1);
      wr(8'h24, 32'h1);
      rc(8'h1c, 32'h0);
   endtask : t_oneshot

   // Trigger spacing in periodic mode: reload cycle plus two prescaled steps
   task automatic t_prescale;
      int ps [3] = '{0, 3, 255};
      int n;
      wr(8'h04, 32'h2);
      foreach (ps[i]) begin
         wr(8'h00, 32'h0);
         wr(8'h10, 32'(ps[i]));
         wr(8'h08, 32'h2);
         wr(8'h00, 32'h11);
         n = 0;
         while (trig !== 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
         end
         n = 0;
         do begin
            @(posedge clk);
            n++;
         end while (trig !== 1'b1 && n < 2000);
         chk(32'(n), 32'(2 * ps[i] + 3));
      end
   endtask : t_prescale

   task automatic t_stall;
      logic [31:0] q1, q2;
      wr(8'h08, 32'h100);
      rc(8'h14, 32'h100);
      wr(8'h00, 32'h13);
      rd(8'h14, q1);
      repeat (600) @(posedge clk);
      rc(8'h14, q1);
      wr(8'h00, 32'h11);
      repeat (600) @(posedge clk);
      rd(8'h14, q2);
      chk(32'(q2 < q1), 32'h1);
   endtask : t_stall

   task automatic t_count;
      logic [1:0] ev [3] = '{2'h0, 2'h1, 2'h3};
      foreach (ev[i]) begin
         wr(8'h00, 32'h0);
         wr(8'h04, 32'h3);
         wr(8'h08, 32'h4);
         wr(8'h0c, 32'h2);
         wr(8'h24, 32'h7);
         wr(8'h00, {28'h0, ev[i], 2'b01});
         u_pin.toggle();
         u_pin.toggle();
         rc(8'h14, (ev[i] == 2'h3) ? 32'h4 : 32'h3);
         u_pin.toggle();
         u_pin.toggle();
         rc(8'h14, 32'h4);
         rc(8'h1c, 32'h2);
         rc(8'h00, {28'h0, ev[i], 2'b00});
      end
   endtask : t_count

   // Prescale left at maximum: capture spacing must still be one count a clock
   task automatic t_time;
      logic [31:0] a, b;
      int          t1, t2;
      wr(8'h00, 32'h0);
      wr(8'h10, 32'hff);
      wr(8'h04, 32'h7);
      wr(8'h08, 32'hffff);
      wr(8'h24, 32'h7);
      rc(8'h14, 32'hffff);
      wr(8'h00, 32'h1);
      u_pin.toggle();
      t1 = cnt;
      rd(8'h14, a);
      rc(8'h14, a);
      rc(8'h1c, 32'h4);
      u_pin.toggle();
      u_pin.toggle();
      t2 = cnt;
      rd(8'h14, b);
      chk({16'h0, a[15:0] - b[15:0]}, 32'(t2 - t1));
   endtask : t_time

   task automatic t_pwm;
      int n;
      wr(8'h00, 32'h0);
      wr(8'h10, 32'h0);
      wr(8'h04, 32'ha);
      wr(8'h08, 32'h9);
      wr(8'h0c, 32'h3);
      wr(8'h24, 32'h7);
      for (int v = 0; v < 2; v++) begin
         wr(8'h00, v ? 32'h31 : 32'h11);
         repeat (30) @(posedge clk);
         n = 0;
         repeat (10) begin
            @(posedge clk);
            n += (pin_out === 1'b1);
         end
         chk(32'(n), v ? 32'h4 : 32'h6);
         chk(32'(oe_n), 32'h0);
      end
      rc(8'h1c, 32'h0);
      chk(32'(irq), 32'h0);
   endtask : t_pwm

   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : stop_test

   // Main sequence
   initial begin
      rst = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h0;
      dat = 32'h0;
      fails = 0;
      num_checks = 0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_oneshot();
      t_prescale();
      t_stall();
      t_count();
      t_time();
      t_pwm();
      stop_test();
   end

   // Watchdog, well beyond the few thousand cycles the run needs
   initial begin
      repeat (40000) @(posedge clk);
      fails++;
      stop_test();
   end
endmodule : tb_gp_timer_16bit
`default_nettype wire

// ===== verilog/capture_edge_detect.sv
// Synchroniser and edge detector for the capture/compare pin
`default_nettype none
module capture_edge_detect (
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic pin_in,
   input  wire logic rise_select,
   input  wire logic fall_select,
   output logic      edge_pulse
);

   logic sync_first;
   logic sync_second;
   logic sync_prev;

   // Two-stage synchroniser; only the second stage reads the first
   always_ff @(posedge clock) begin
      if (rst) begin
         sync_first  <= 1'b0;
         sync_second <= 1'b0;
      end else begin
         sync_first  <= pin_in;
         sync_second <= sync_first;
      end
   end

   // History stage for edge detection
   always_ff @(posedge clock) begin
      if (rst) begin
         sync_prev <= 1'b0;
      end else begin
         sync_prev <= sync_second;
      end
   end

   // One pulse per selected edge, so each edge is seen exactly once
   always_comb begin
      edge_pulse = (rise_select & sync_second & ~sync_prev)
                 | (fall_select & ~sync_second & sync_prev);
   end

endmodule : capture_edge_detect
`default_nettype wire

// ===== verilog/gp_timer_16bit.sv
// 16-bit timer half: one-shot, periodic, edge count, edge time and PWM modes
//
// Functional notes
// - Zero count sets sticky timeout raw status
// - Unmasked raw timeout sets masked bit, interrupt
// - Trigger enabled: one-cycle pulse at zero
// - Load write reloads counter next cycle
// - Stall bit freezes counter, release resumes
// - Prescale p gives p+1 clocks per decrement
// - Edge count: down-count selected pin edges
// - Capture type 0 count, 1 time
// - Each selected edge decrements until match
// - Match: status, masked, reload, clear enable
// - After match ignore edges until re-enable
// - Edge time mode runs without prescaler
// - Edge time free-runs from load, reset ffff
// - Edge copies count, sets capture event status
// - Edge time keeps counting, reloads at zero
// - Captured value held until next edge
// - PWM: alt select 1, type 0, mode 2
// - PWM counts down, reloads, runs until disabled
// - PWM sets no status, no interrupt
// - PWM active at load, inactive at match
// - Invert bit inverts PWM output
// - One-shot stops, clears enable; periodic continues
// - Mode 3 means capture, type selects kind
// - Reset: counter, load ffff, prescale zero, idle
`default_nettype none
`include "gp_timer_regs.svh"
module gp_timer_16bit (
   input  wire logic        CLOCK,
   input  wire logic        RST,
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_WE_I,
   input  wire logic [7:0]  WB_ADR_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic [31:0] WB_DAT_I,
   output logic      [31:0] WB_DAT_O,
   output logic             WB_ACK_O,
   input  wire logic        CAPTURE_COMPARE_PIN_IN,
   output logic             CAPTURE_COMPARE_PIN_OUT,
   output logic             CAPTURE_COMPARE_PIN_OE_N,
   output logic             TRIGGER_OUT,
   output logic             IRQ
);

   gp_timer_pkg::timer_control_t timer_control_reg;
   gp_timer_pkg::timer_mode_t    timer_mode_reg;
   gp_timer_pkg::irq_status_t    raw_irq_status_reg;
   gp_timer_pkg::irq_status_t    irq_mask_reg;
   gp_timer_pkg::irq_status_t    masked_irq_status_reg;
   gp_timer_pkg::irq_status_t    set_status;
   gp_timer_pkg::irq_status_t    clear_status;
   gp_timer_pkg::op_mode_t       op_mode;

   logic [15:0] interval_load_reg;
   logic [15:0] match_value_reg;
   logic [7:0]  prescale_reg;
   logic [15:0] counter;
   logic [7:0]  prescale_count;
   logic [15:0] timer_value_reg;
   logic [15:0] next_counter;
   logic [7:0]  next_prescale_count;
   logic        next_pwm_level;
   logic        pwm_level;
   logic        running;
   logic        edge_pulse;
   logic        rise_select;
   logic        fall_select;
   logic        timeout_event;
   logic        match_event;
   logic        capture_event;
   logic        auto_disable;
   logic        bus_request;
   logic        bus_write;
   logic [31:0] read_data;
   logic [31:0] write_word;

   // Apply the byte enables to a register's present contents
   function automatic logic [31:0] merge_bytes(input logic [31:0] old_word,
                                               input logic [31:0] new_word,
                                               input logic [3:0]  sel);
      logic [31:0] result;
      result = old_word;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            result[i*8 +: 8] = new_word[i*8 +: 8];
         end
      end
      return result;
   endfunction : merge_bytes

   // Bus handshake: ack one cycle after the strobe, write on the ack edge
   assign bus_request = WB_CYC_I & WB_STB_I;
   assign bus_write   = bus_request & WB_WE_I & WB_ACK_O;

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         WB_ACK_O <= 1'b0;
      end else begin
         WB_ACK_O <= bus_request & ~WB_ACK_O;
      end
   end

   // Decode the operating mode from the mode word
   always_comb begin
      op_mode = gp_timer_pkg::OP_IDLE;
      if (timer_mode_reg.alternate_mode_select) begin
         if (!timer_mode_reg.capture_type_bit &&
             timer_mode_reg.timer_mode_field == `MODE_FIELD_PERIODIC) begin
            op_mode = gp_timer_pkg::OP_PWM;
         end
      end else begin
         case (timer_mode_reg.timer_mode_field)
            `MODE_FIELD_ONE_SHOT: op_mode = gp_timer_pkg::OP_ONE_SHOT;
            `MODE_FIELD_PERIODIC: op_mode = gp_timer_pkg::OP_PERIODIC;
            `MODE_FIELD_CAPTURE: begin
               // Capture type picks counting or timing of edges
               if (timer_mode_reg.capture_type_bit) begin
                  op_mode = gp_timer_pkg::OP_EDGE_TIME;
               end else begin
                  op_mode = gp_timer_pkg::OP_EDGE_COUNT;
               end
            end
            default: op_mode = gp_timer_pkg::OP_IDLE;
         endcase
      end
   end

   // Edge selection from the event field
   assign rise_select = (timer_control_reg.edge_event_field == `EDGE_RISING)
                      | (timer_control_reg.edge_event_field == `EDGE_BOTH);
   assign fall_select = (timer_control_reg.edge_event_field == `EDGE_FALLING)
                      | (timer_control_reg.edge_event_field == `EDGE_BOTH);

   capture_edge_detect pin_edges (
      .clock       (CLOCK),
      .rst         (RST),
      .pin_in      (CAPTURE_COMPARE_PIN_IN),
      .rise_select (rise_select),
      .fall_select (fall_select),
      .edge_pulse  (edge_pulse)
   );

   // Stall freezes every mode in place
   assign running = timer_control_reg.timer_enable_bit
                  & ~timer_control_reg.stall_control_bit;

   // Counting engine per mode
   always_comb begin
      next_counter        = counter;
      next_prescale_count = prescale_count;
      timeout_event       = 1'b0;
      match_event         = 1'b0;
      capture_event       = 1'b0;
      auto_disable        = 1'b0;
      case (op_mode)
         gp_timer_pkg::OP_ONE_SHOT,
         gp_timer_pkg::OP_PERIODIC,
         gp_timer_pkg::OP_PWM: begin
            if (running) begin
               if (counter == 16'h0000) begin
                  // Reload one cycle after zero, without waiting for the prescaler
                  next_counter        = interval_load_reg;
                  next_prescale_count = prescale_reg;
                  auto_disable        = (op_mode == gp_timer_pkg::OP_ONE_SHOT);
               end else if (prescale_count != 8'h00) begin
                  next_prescale_count = prescale_count - 8'h01;
               end else begin
                  next_counter        = counter - 16'h0001;
                  next_prescale_count = prescale_reg;
                  // PWM raises no status on zero
                  timeout_event = (counter == 16'h0001)
                                & (op_mode != gp_timer_pkg::OP_PWM);
               end
            end
         end
         gp_timer_pkg::OP_EDGE_COUNT: begin
            // Enable drops on match, so later edges fall through here
            if (running && edge_pulse) begin
               if (counter - 16'h0001 == match_value_reg) begin
                  match_event  = 1'b1;
                  next_counter = interval_load_reg;
                  auto_disable = 1'b1;
               end else begin
                  next_counter = counter - 16'h0001;
               end
            end
         end
         gp_timer_pkg::OP_EDGE_TIME: begin
            if (running) begin
               // Undivided clock; the prescaler is bypassed here
               if (counter == 16'h0000) begin
                  next_counter = interval_load_reg;
               end else begin
                  next_counter = counter - 16'h0001;
               end
               capture_event = edge_pulse;
            end
         end
         default: begin
            next_counter = counter;
         end
      endcase
   end

   // Counter and prescale counter; a load write overrides counting
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         counter        <= `RST_COUNTER;
         prescale_count <= `RST_PRESCALE;
      end else if (bus_write && WB_ADR_I == `OFS_INTERVAL_LOAD) begin
         counter        <= write_word[15:0];
         prescale_count <= prescale_reg;
      end else begin
         counter        <= next_counter;
         prescale_count <= next_prescale_count;
      end
   end

   // Captured count, held until the next selected edge
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         timer_value_reg <= `RST_CAPTURED;
      end else if (capture_event) begin
         timer_value_reg <= counter;
      end
   end

   // Write word merged per byte lane into the target's present value; the read
   // view of every writable register except the clear, which reads zero, is that register zero-extended
   assign write_word = merge_bytes(read_data, WB_DAT_I, WB_SEL_I);

   // Control word; a software write wins over the automatic disable
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         timer_control_reg <= '0;
      end else if (bus_write && WB_ADR_I == `OFS_TIMER_CONTROL) begin
         timer_control_reg <= write_word[`CTRL_WIDTH-1:0];
      end else if (auto_disable) begin
         timer_control_reg.timer_enable_bit <= 1'b0;
      end
   end

   // Configuration words written by software
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         timer_mode_reg    <= '0;
         interval_load_reg <= `RST_INTERVAL_LOAD;
         match_value_reg   <= `RST_MATCH_VALUE;
         prescale_reg      <= `RST_PRESCALE;
         irq_mask_reg      <= '0;
      end else if (bus_write) begin
         case (WB_ADR_I)
            `OFS_TIMER_MODE:    timer_mode_reg    <= write_word[`MODE_WIDTH-1:0];
            `OFS_INTERVAL_LOAD: interval_load_reg <= write_word[15:0];
            `OFS_MATCH_VALUE:   match_value_reg   <= write_word[15:0];
            `OFS_PRESCALE:      prescale_reg      <= write_word[7:0];
            `OFS_IRQ_MASK:      irq_mask_reg      <= write_word[`STAT_WIDTH-1:0];
            default:            timer_mode_reg    <= timer_mode_reg;
         endcase
      end
   end

   // Status events and write-one-to-clear requests
   always_comb begin
      set_status.timeout       = timeout_event;
      set_status.capture_match = match_event;
      set_status.capture_event = capture_event;
      clear_status = '0;
      if (bus_write && WB_ADR_I == `OFS_IRQ_CLEAR) begin
         clear_status = write_word[`STAT_WIDTH-1:0];
      end
   end

   // Sticky raw status; a set in the clearing cycle is kept
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         raw_irq_status_reg <= '0;
      end else begin
         raw_irq_status_reg <= set_status
                             | (raw_irq_status_reg & ~clear_status);
      end
   end

   // Masked view follows raw status through the mask
   assign masked_irq_status_reg = raw_irq_status_reg & irq_mask_reg;

   // Interrupt and trigger lines, both registered
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         IRQ         <= 1'b0;
         TRIGGER_OUT <= 1'b0;
      end else begin
         IRQ         <= |((set_status | (raw_irq_status_reg & ~clear_status))
                          & irq_mask_reg);
         TRIGGER_OUT <= timeout_event & timer_control_reg.trigger_out_enable;
      end
   end

   // PWM level follows the counter value that is about to be shown
   always_comb begin
      next_pwm_level = pwm_level;
      if (op_mode != gp_timer_pkg::OP_PWM || !timer_control_reg.timer_enable_bit) begin
         next_pwm_level = 1'b0;
      end else if (next_counter == interval_load_reg) begin
         next_pwm_level = 1'b1;
      end else if (next_counter == match_value_reg) begin
         next_pwm_level = 1'b0;
      end
   end

   // Pin drive: only PWM mode turns the pin into an output
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         pwm_level                <= 1'b0;
         CAPTURE_COMPARE_PIN_OUT  <= 1'b0;
         CAPTURE_COMPARE_PIN_OE_N <= 1'b1;
      end else begin
         pwm_level                <= next_pwm_level;
         CAPTURE_COMPARE_PIN_OUT  <= (next_pwm_level ^ timer_control_reg.pwm_output_level_invert)
                                   & (op_mode == gp_timer_pkg::OP_PWM);
         CAPTURE_COMPARE_PIN_OE_N <= (op_mode != gp_timer_pkg::OP_PWM);
      end
   end

   // Read multiplexer; unmapped offsets read zero
   always_comb begin
      read_data = 32'h0000_0000;
      case (WB_ADR_I)
         `OFS_TIMER_CONTROL:     read_data = {26'h0, timer_control_reg};
         `OFS_TIMER_MODE:        read_data = {28'h0, timer_mode_reg};
         `OFS_INTERVAL_LOAD:     read_data = {16'h0, interval_load_reg};
         `OFS_MATCH_VALUE:       read_data = {16'h0, match_value_reg};
         `OFS_PRESCALE:          read_data = {24'h0, prescale_reg};
         `OFS_TIMER_VALUE: begin
            // Edge time shows the capture, other modes the live count
            if (op_mode == gp_timer_pkg::OP_EDGE_TIME) begin
               read_data = {16'h0, timer_value_reg};
            end else begin
               read_data = {16'h0, counter};
            end
         end
         `OFS_IRQ_MASK:          read_data = {29'h0, irq_mask_reg};
         `OFS_RAW_IRQ_STATUS:    read_data = {29'h0, raw_irq_status_reg};
         `OFS_MASKED_IRQ_STATUS: read_data = {29'h0, masked_irq_status_reg};
         default:                read_data = 32'h0000_0000;
      endcase
   end

   // Read data captured together with the ack
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         WB_DAT_O <= 32'h0000_0000;
      end else if (bus_request && !WB_ACK_O) begin
         WB_DAT_O <= read_data;
      end
   end

endmodule : gp_timer_16bit
`default_nettype wire

// ===== verilog/gp_timer_pkg.sv
// Types shared by the 16-bit timer half
`default_nettype none
package gp_timer_pkg;

   // Software control word
   typedef struct packed {
      logic       pwm_output_level_invert;
      logic       trigger_out_enable;
      logic [1:0] edge_event_field;
      logic       stall_control_bit;
      logic       timer_enable_bit;
   } timer_control_t;

   // Software mode word
   typedef struct packed {
      logic       alternate_mode_select;
      logic       capture_type_bit;
      logic [1:0] timer_mode_field;
   } timer_mode_t;

   // Status flags, same layout for raw, mask, masked and clear
   typedef struct packed {
      logic capture_event;
      logic capture_match;
      logic timeout;
   } irq_status_t;

   // Operating mode decoded from the mode word, Gray along the usual path
   typedef enum logic [2:0] {
      OP_IDLE       = 3'h0,
      OP_ONE_SHOT   = 3'h1,
      OP_PERIODIC   = 3'h3,
      OP_EDGE_COUNT = 3'h2,
      OP_EDGE_TIME  = 3'h6,
      OP_PWM        = 3'h7
   } op_mode_t;

endpackage : gp_timer_pkg
`default_nettype wire

// ===== verilog/gp_timer_regs.svh
// Register offsets, reset values and bus constants of the 16-bit timer half
`ifndef GP_TIMER_REGS_SVH
`define GP_TIMER_REGS_SVH

// Byte offsets on the Wishbone bus, one aligned 32-bit word each
`define OFS_TIMER_CONTROL     8'h00
`define OFS_TIMER_MODE        8'h04
`define OFS_INTERVAL_LOAD     8'h08
`define OFS_MATCH_VALUE       8'h0c
`define OFS_PRESCALE          8'h10
`define OFS_TIMER_VALUE       8'h14
`define OFS_IRQ_MASK          8'h18
`define OFS_RAW_IRQ_STATUS    8'h1c
`define OFS_MASKED_IRQ_STATUS 8'h20
`define OFS_IRQ_CLEAR         8'h24

// Control word bit positions
`define CTRL_ENABLE_BIT       0
`define CTRL_STALL_BIT        1
`define CTRL_EDGE_EVENT_LSB   2
`define CTRL_TRIG_OUT_EN_BIT  4
`define CTRL_PWM_INVERT_BIT   5
`define CTRL_WIDTH            6

// Mode word bit positions
`define MODE_FIELD_LSB        0
`define MODE_CAPTURE_TYPE_BIT 2
`define MODE_ALT_SELECT_BIT   3
`define MODE_WIDTH            4

// Status bit positions (raw, mask, masked and clear share the layout)
`define STAT_TIMEOUT_BIT      0
`define STAT_CAPT_MATCH_BIT   1
`define STAT_CAPT_EVENT_BIT   2
`define STAT_WIDTH            3

// Mode field encodings
`define MODE_FIELD_ONE_SHOT   2'h1
`define MODE_FIELD_PERIODIC   2'h2
`define MODE_FIELD_CAPTURE    2'h3

// Edge event encodings
`define EDGE_RISING           2'h0
`define EDGE_FALLING          2'h1
`define EDGE_BOTH             2'h3

// Reset values
`define RST_INTERVAL_LOAD     16'hffff
`define RST_COUNTER           16'hffff
`define RST_CAPTURED          16'hffff
`define RST_PRESCALE          8'h00
`define RST_MATCH_VALUE       16'h0000

`endif
